// [src/ttc_defines.svh]
// Constants of the three-timer counter unit: fields, reset values, timings
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH

// Clock rate and machine cycle
`define TTC_CLK_HZ 40000000
`define TTC_MC_CLKS 4
// Time-base dividers and prescaler width
`define TTC_SLOW_DIV 12
`define TTC_FAST_DIV 4
`define TTC_PRE_W 4

// Mode register fields, first timer in low nibble
`define TTC_M0_LSB 0
`define TTC_CT0_BIT 2
`define TTC_GATE0_BIT 3
`define TTC_M1_LSB 4
`define TTC_CT1_BIT 6
`define TTC_GATE1_BIT 7

// General timer modes
`define TTC_MODE_13 2'h0
`define TTC_MODE_16 2'h1
`define TTC_MODE_RELOAD 2'h2
`define TTC_MODE_SPLIT 2'h3

// Mode 0 prescale field of the low byte
`define TTC_M0_LO_MAX 5'h1f

// Count register write selects
`define TTC_SEL_TL0 3'h0
`define TTC_SEL_TH0 3'h1
`define TTC_SEL_TL1 3'h2
`define TTC_SEL_TH1 3'h3
`define TTC_SEL_TL2 3'h4
`define TTC_SEL_TH2 3'h5
`define TTC_SEL_CAPL 3'h6
`define TTC_SEL_CAPH 3'h7

// Reset values and word maximum
`define TTC_BYTE_RST 8'h00
`define TTC_WORD_RST 16'h0000
`define TTC_SPEED_RST 1'b0
`define TTC_WORD_MAX 16'hffff

`endif

// [src/ttc_pin_sampler.sv]
// Once-per-machine-cycle sampler of a count or trigger pin
`timescale 1ns/100ps
`include "ttc_defines.svh"
module ttc_pin_sampler import ttc_pkg::*; (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Machine-cycle tick and pin
	input wire logic tick_in,
	input wire logic pin_in,
	// Sampled level and recognised falling edge
	output logic level_out,
	output logic fall_out
);
	// Last sample taken
	logic samp_q;
	// One-cycle pulse after a high sample then a low sample
	logic fall_q;

	// Sample at the tick; a pulse narrower than a machine cycle may be missed
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			samp_q <= 1'b1;
			fall_q <= 1'b0;
		end else if (ce_in) begin
			if (tick_in) begin
				samp_q <= pin_in;
				fall_q <= samp_q & ~pin_in;
			end else begin
				fall_q <= 1'b0;
			end
		end
	end

	assign level_out = samp_q;
	assign fall_out = fall_q;
endmodule // ttc_pin_sampler

// [src/ttc_pkg.sv]
// Types shared by the three-timer counter unit
package ttc_pkg;
	// Working modes of the third timer
	typedef enum logic [1:0] {
		TTC_T2_CAPTURE,
		TTC_T2_RELOAD_UP,
		TTC_T2_UPDOWN,
		TTC_T2_BAUD
	} ttc_t2_mode_e;
	typedef logic [7:0] ttc_byte_t;
	typedef logic [15:0] ttc_word_t;
endpackage

// [src/ttc_top.sv]
// Three-timer counter unit: two general timers and an up/down third timer
// Contract
// - Speed bit picks divide-by-12 or divide-by-4
// - Reset clears all three speed select bits
// - Mode 0 is 13 bits, low-byte top ignored
// - Mode 0 carries at bit 4, wraps, sets flag
// - Count needs run bit and gate or pin
// - Function bit picks time-base or pin falls
// - Mode 1 is 16 bits, wrap sets flag
// - Mode 2 reloads low from high byte
// - Mode 3 freezes the second timer
// - Split mode: high byte uses second run bit and flag
// - Second timer runs without run or flag
// - Third timer clock from pin or divider
// - Capture mode counts up, wrap sets flag
// - Trigger fall captures count, sets external flag
// - Capture-clear zeroes count after capture
// - Up reload mode reloads from capture registers
// - Trigger fall also reloads in up mode
// - Up/down: pin sets direction, two reloads
// - Up/down reload toggles external flag, no request
// - Baud mode reloads without overflow flag
// - Clock-out gives 50% clock, no request
// - Clock-out period is four times capture
// - Count and trigger pins sampled per machine cycle, hold levels
// - Mode register function bits 2 and 6
`timescale 1ns/100ps
`include "ttc_defines.svh"
module ttc_top import ttc_pkg::*; (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// General timer controls
	input wire logic [7:0] timer_mode_register_in,
	input wire logic [1:0] run_bit_in,
	input wire logic timer_zero_speed_select_in,
	input wire logic timer_one_speed_select_in,
	// Third timer controls
	input wire logic third_speed_select_in,
	input wire logic third_source_select_in,
	input wire logic third_run_bit_in,
	input wire logic capture_reload_select_in,
	input wire logic trigger_enable_in,
	input wire logic capture_clear_bit_in,
	input wire logic down_count_enable_in,
	input wire logic receive_baud_select_in,
	input wire logic transmit_baud_select_in,
	input wire logic clock_out_enable_in,
	// Pins
	input wire logic [1:0] external_interrupt_pin_in,
	input wire logic first_count_pin_in,
	input wire logic second_count_pin_in,
	input wire logic third_count_pin_in,
	input wire logic trigger_pin_in,
	// Count register writes
	input wire logic wr_en_in,
	input wire logic [2:0] wr_sel_in,
	input wire logic [7:0] wr_data_in,
	// Flag clears
	input wire logic [1:0] clr_overflow_flag_in,
	input wire logic clr_third_overflow_flag_in,
	input wire logic clr_external_flag_in,
	// Counts and flags
	output logic [15:0] timer0_count_out,
	output logic [15:0] timer1_count_out,
	output logic [15:0] timer2_count_out,
	output logic [15:0] capture_out,
	output logic [1:0] overflow_flag_out,
	output logic third_overflow_flag_out,
	output logic external_flag_out,
	// Requests and clocks
	output logic irq_timer0_out,
	output logic irq_timer1_out,
	output logic irq_timer2_out,
	output logic baud_tick_out,
	output logic clock_out_pin_out
);
	// Prescaler state and ticks
	logic [`TTC_PRE_W-1:0] pre_q;
	logic tick_fast, tick_slow;
	// Registered speed selects
	logic spd0_q, spd1_q, spd2_q;
	// Count bytes and flags
	ttc_byte_t tl0_q, th0_q, tl1_q, th1_q, tl2_q, th2_q, capl_q, caph_q;
	logic tf0_q, tf1_q, tf2_q, external_flag_q;
	// Pin sampler results
	logic [3:0] pins, pin_lvl, pin_fall;
	// Mode fields
	logic [1:0] m0, m1;
	logic split0;
	// Count enables
	logic tb0, tb1, tb2, en0, en1, en_th0, en2;
	// General timer next values
	logic [16:0] step0, step1;
	ttc_byte_t tl0_d, th0_d, tl1_d, th1_d;
	logic set_tf0, set_tf1;
	// Third timer working values
	ttc_t2_mode_e t2_mode;
	logic co_mode, baud_mode, trig;
	ttc_word_t t2_cnt, t2_d, cap_d;
	logic set_tf2, set_external_flag, tog_external_flag, baud_d, cap_hit;
	// Clock-out generator
	logic [16:0] co_cnt_q;
	logic co_q, irq2_q, baud_q;

	// One step of a general timer in modes 0 to 2; mode 3 holds
	function automatic logic [16:0] gt_step(input logic [1:0] m,
			input ttc_word_t c);
		logic [16:0] r;
		r = {1'b0, c};
		case (m)
			`TTC_MODE_13: begin
				r[4:0] = c[4:0] + 5'h01;
				if (c[4:0] == `TTC_M0_LO_MAX) begin
					{r[16], r[15:8]} = {1'b0, c[15:8]} + 9'h001;
				end
			end
			`TTC_MODE_16: r = {1'b0, c} + 17'h00001;
			`TTC_MODE_RELOAD: begin
				if (c[7:0] == 8'hff) begin
					r = {1'b1, c[15:8], c[15:8]};
				end else begin
					r[7:0] = c[7:0] + 8'h01;
				end
			end
			default: r = {1'b0, c};
		endcase
		return r;
	endfunction

	// Machine cycle prescaler; 12 is a multiple of 4 so both share it
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre_q <= '0;
		end else if (ce_in) begin
			if (pre_q == `TTC_PRE_W'(`TTC_SLOW_DIV - 1)) begin
				pre_q <= '0;
			end else begin
				pre_q <= pre_q + `TTC_PRE_W'(1);
			end
		end
	end
	assign tick_fast = (pre_q[1:0] == 2'(`TTC_FAST_DIV - 1));
	assign tick_slow = (pre_q == `TTC_PRE_W'(`TTC_SLOW_DIV - 1));

	// Speed selects; reset falls back to the slow time-base
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			spd0_q <= `TTC_SPEED_RST;
			spd1_q <= `TTC_SPEED_RST;
			spd2_q <= `TTC_SPEED_RST;
		end else if (ce_in) begin
			spd0_q <= timer_zero_speed_select_in;
			spd1_q <= timer_one_speed_select_in;
			spd2_q <= third_speed_select_in;
		end
	end

	// Pin samplers, one per count pin and the trigger pin, sampled each machine cycle
	assign pins = {trigger_pin_in, third_count_pin_in,
		second_count_pin_in, first_count_pin_in};
	generate
		for (genvar i = 0; i < 4; i++) begin : g_pin
			ttc_pin_sampler u_samp (
				.sys_clk_in(sys_clk_in),
				.rst_in(rst_in),
				.ce_in(ce_in),
				.tick_in(tick_fast),
				.pin_in(pins[i]),
				.level_out(pin_lvl[i]),
				.fall_out(pin_fall[i])
			);
		end
	endgenerate

	// General timer enables
	assign m0 = timer_mode_register_in[`TTC_M0_LSB +: 2];
	assign m1 = timer_mode_register_in[`TTC_M1_LSB +: 2];
	assign split0 = (m0 == `TTC_MODE_SPLIT);
	assign tb0 = spd0_q ? tick_fast : tick_slow;
	assign tb1 = spd1_q ? tick_fast : tick_slow;
	// Gate lets the interrupt pin hold the count off
	assign en0 = run_bit_in[0]
		& (~timer_mode_register_in[`TTC_GATE0_BIT]
		| external_interrupt_pin_in[0])
		& (timer_mode_register_in[`TTC_CT0_BIT] ? pin_fall[0] : tb0);
	// Second run bit goes to the split high byte in split mode
	assign en1 = (split0 | run_bit_in[1])
		& (~timer_mode_register_in[`TTC_GATE1_BIT]
		| external_interrupt_pin_in[1])
		& (timer_mode_register_in[`TTC_CT1_BIT] ? pin_fall[1] : tb1);
	assign en_th0 = run_bit_in[1] & tb0;
	assign step0 = gt_step(m0, {th0_q, tl0_q});
	assign step1 = gt_step(m1, {th1_q, tl1_q});

	// Next values of the general timers
	always_comb begin
		tl0_d = tl0_q;
		th0_d = th0_q;
		tl1_d = tl1_q;
		th1_d = th1_q;
		set_tf0 = 1'b0;
		set_tf1 = 1'b0;
		if (split0) begin
			// Two 8-bit counters, high byte is clock-only
			if (en0) begin
				{set_tf0, tl0_d} = {1'b0, tl0_q} + 9'h001;
			end
			if (en_th0) begin
				{set_tf1, th0_d} = {1'b0, th0_q} + 9'h001;
			end
		end else if (en0) begin
			{set_tf0, th0_d, tl0_d} = step0;
		end
		if (en1 && m1 != `TTC_MODE_SPLIT) begin
			th1_d = step1[15:8];
			tl1_d = step1[7:0];
			// Flag belongs to the split high byte meanwhile
			set_tf1 = set_tf1 | (step1[16] & ~split0);
		end
	end

	// General count registers; a write beats a count in that byte
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tl0_q <= `TTC_BYTE_RST;
			th0_q <= `TTC_BYTE_RST;
			tl1_q <= `TTC_BYTE_RST;
			th1_q <= `TTC_BYTE_RST;
		end else if (ce_in) begin
			tl0_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TL0) ? wr_data_in : tl0_d;
			th0_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TH0) ? wr_data_in : th0_d;
			tl1_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TL1) ? wr_data_in : tl1_d;
			th1_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TH1) ? wr_data_in : th1_d;
		end
	end

	// Overflow flags; a set in the clearing cycle wins
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tf0_q <= 1'b0;
			tf1_q <= 1'b0;
		end else if (ce_in) begin
			tf0_q <= set_tf0 | (tf0_q & ~clr_overflow_flag_in[0]);
			tf1_q <= set_tf1 | (tf1_q & ~clr_overflow_flag_in[1]);
		end
	end

	// Third timer mode; baud and clock-out take over reload handling
	assign co_mode = clock_out_enable_in & ~third_source_select_in
		& ~capture_reload_select_in;
	assign baud_mode = receive_baud_select_in | transmit_baud_select_in
		| co_mode;
	always_comb begin
		if (baud_mode) begin
			t2_mode = TTC_T2_BAUD;
		end else if (capture_reload_select_in) begin
			t2_mode = TTC_T2_CAPTURE;
		end else if (down_count_enable_in) begin
			t2_mode = TTC_T2_UPDOWN;
		end else begin
			t2_mode = TTC_T2_RELOAD_UP;
		end
	end
	assign tb2 = spd2_q ? tick_fast : tick_slow;
	assign en2 = third_run_bit_in
		& (third_source_select_in ? pin_fall[2] : tb2);
	assign trig = trigger_enable_in & pin_fall[3];
	assign t2_cnt = {th2_q, tl2_q};
	assign cap_hit = (t2_cnt == {caph_q, capl_q});

	// Third timer next values
	always_comb begin
		t2_d = t2_cnt;
		cap_d = {caph_q, capl_q};
		set_tf2 = 1'b0;
		set_external_flag = 1'b0;
		tog_external_flag = 1'b0;
		baud_d = 1'b0;
		case (t2_mode)
			TTC_T2_CAPTURE: begin
				if (en2) begin
					{set_tf2, t2_d} = {1'b0, t2_cnt} + 17'h00001;
				end
				if (trig) begin
					cap_d = t2_cnt;
					set_external_flag = 1'b1;
					if (capture_clear_bit_in) begin
						t2_d = `TTC_WORD_RST;
					end
				end
			end
			TTC_T2_RELOAD_UP: begin
				if (trig) begin
					t2_d = cap_d;
					set_external_flag = 1'b1;
				end else if (en2 && t2_cnt == `TTC_WORD_MAX) begin
					t2_d = cap_d;
					set_tf2 = 1'b1;
				end else if (en2) begin
					t2_d = t2_cnt + 16'h0001;
				end
			end
			TTC_T2_UPDOWN: begin
				// Direction follows the sampled trigger pin level
				if (en2 && pin_lvl[3]) begin
					if (t2_cnt == `TTC_WORD_MAX) begin
						t2_d = cap_d;
						set_tf2 = 1'b1;
						tog_external_flag = 1'b1;
					end else begin
						t2_d = t2_cnt + 16'h0001;
					end
				end else if (en2) begin
					if (cap_hit) begin
						t2_d = `TTC_WORD_MAX;
						set_tf2 = 1'b1;
						tog_external_flag = 1'b1;
					end else begin
						t2_d = t2_cnt - 16'h0001;
					end
				end
			end
			TTC_T2_BAUD: begin
				if (en2 && t2_cnt == `TTC_WORD_MAX) begin
					t2_d = cap_d;
					baud_d = 1'b1;
				end else if (en2) begin
					t2_d = t2_cnt + 16'h0001;
				end
				set_external_flag = trig;
			end
			default: t2_d = t2_cnt;
		endcase
	end

	// Third timer and capture registers; hardware capture beats a write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tl2_q <= `TTC_BYTE_RST;
			th2_q <= `TTC_BYTE_RST;
			capl_q <= `TTC_BYTE_RST;
			caph_q <= `TTC_BYTE_RST;
		end else if (ce_in) begin
			tl2_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TL2) ? wr_data_in
				: t2_d[7:0];
			th2_q <= (wr_en_in && wr_sel_in == `TTC_SEL_TH2) ? wr_data_in
				: t2_d[15:8];
			capl_q <= (wr_en_in && wr_sel_in == `TTC_SEL_CAPL && !set_external_flag)
				? wr_data_in : cap_d[7:0];
			caph_q <= (wr_en_in && wr_sel_in == `TTC_SEL_CAPH && !set_external_flag)
				? wr_data_in : cap_d[15:8];
		end
	end

	// Third timer flags and the baud pulse for the serial port
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			tf2_q <= 1'b0;
			external_flag_q <= 1'b0;
			baud_q <= 1'b0;
		end else if (ce_in) begin
			tf2_q <= set_tf2 | (tf2_q & ~clr_third_overflow_flag_in);
			if (set_external_flag) begin
				external_flag_q <= 1'b1;
			end else if (tog_external_flag) begin
				external_flag_q <= ~external_flag_q;
			end else if (clr_external_flag_in) begin
				external_flag_q <= 1'b0;
			end
			baud_q <= baud_d;
		end
	end

	// Combined third request; external flag muted in up/down mode
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq2_q <= 1'b0;
		end else if (ce_in) begin
			irq2_q <= tf2_q | (external_flag_q & (t2_mode != TTC_T2_UPDOWN));
		end
	end

	// Clock-out: toggle every 2*capture clocks, so period is 4*capture
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			co_cnt_q <= '0;
			co_q <= 1'b0;
		end else if (ce_in) begin
			if (!co_mode || !third_run_bit_in || cap_d == `TTC_WORD_RST) begin
				co_cnt_q <= '0;
				co_q <= 1'b0;
			end else if (co_cnt_q >= {caph_q, capl_q, 1'b0} - 17'h00001) begin
				co_cnt_q <= '0;
				co_q <= ~co_q;
			end else begin
				co_cnt_q <= co_cnt_q + 17'h00001;
			end
		end
	end

	// Outputs, all taken from flip-flops
	assign timer0_count_out = {th0_q, tl0_q};
	assign timer1_count_out = {th1_q, tl1_q};
	assign timer2_count_out = {th2_q, tl2_q};
	assign capture_out = {caph_q, capl_q};
	assign overflow_flag_out = {tf1_q, tf0_q};
	assign third_overflow_flag_out = tf2_q;
	assign external_flag_out = external_flag_q;
	assign irq_timer0_out = tf0_q;
	assign irq_timer1_out = tf1_q;
	assign irq_timer2_out = irq2_q;
	assign baud_tick_out = baud_q;
	assign clock_out_pin_out = co_q;

	// Checks, frozen while the clock enable is low
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in || !ce_in);

	// Plain count steps with no write in the way, and a capture without clear
	sequence s_t0_m0_top;
		!wr_en_in && m0 == `TTC_MODE_13 && en0
			&& th0_q == 8'hff && tl0_q[4:0] == `TTC_M0_LO_MAX;
	endsequence
	sequence s_t0_m1_top;
		!wr_en_in && m0 == `TTC_MODE_16 && en0 && {th0_q, tl0_q} == 16'hffff;
	endsequence
	sequence s_t0_m2_top;
		!wr_en_in && m0 == `TTC_MODE_RELOAD && en0 && tl0_q == 8'hff;
	endsequence
	sequence s_capture;
		t2_mode == TTC_T2_CAPTURE && trig && !capture_clear_bit_in;
	endsequence

	a_slow_base: assert property (
		tick_slow |=> !tick_slow [*8] ##4 tick_slow)
		else $error("slow time-base off");
	a_mode0_wrap: assert property (
		s_t0_m0_top |=> tl0_q[4:0] == 5'h00 && th0_q == 8'h00 && tf0_q)
		else $error("mode 0 wrap");
	a_mode1_wrap: assert property (
		s_t0_m1_top |=> {th0_q, tl0_q} == 16'h0000 && tf0_q)
		else $error("mode 1 wrap");
	a_mode2_reload: assert property (
		s_t0_m2_top |=> tl0_q == $past(th0_q) && th0_q == $past(th0_q)
		&& tf0_q) else $error("mode 2 reload");
	a_t1_frozen: assert property (
		!wr_en_in && m1 == `TTC_MODE_SPLIT
		|=> $stable(timer1_count_out)) else $error("second timer moved");
	a_run_hold: assert property (
		!wr_en_in && !run_bit_in[0] && !split0
		|=> $stable(timer0_count_out)) else $error("count without run");
	a_capture_copy: assert property (
		s_capture |=> capture_out == $past(timer2_count_out) && external_flag_q)
		else $error("capture lost");
	a_updown_quiet: assert property (
		(t2_mode == TTC_T2_UPDOWN && !tf2_q) [*2] |-> !irq_timer2_out)
		else $error("up/down request");
	a_baud_no_flag: assert property (
		t2_mode == TTC_T2_BAUD && !tf2_q && !clr_third_overflow_flag_in
		|=> !tf2_q && baud_tick_out == $past(baud_d))
		else $error("baud set flag");
endmodule // ttc_top

// [verification/tb_top.sv]
// Self-checking bench of the three-timer counter unit
`timescale 1ns/100ps
module tb_top;
	// Design inputs
	logic sys_clk_in, rst_in, ce_in, wr_en_in, third_speed_select_in;
	logic timer_zero_speed_select_in, timer_one_speed_select_in;
	logic [7:0] timer_mode_register_in, wr_data_in;
	logic [1:0] run_bit_in, external_interrupt_pin_in, clr_overflow_flag_in;
	logic [2:0] wr_sel_in;
	logic clr_third_overflow_flag_in, clr_external_flag_in;
	logic [8:0] t2c; // Third timer controls packed
	wire third_source_select_in, third_run_bit_in, capture_reload_select_in;
	wire trigger_enable_in, capture_clear_bit_in, down_count_enable_in;
	wire receive_baud_select_in, transmit_baud_select_in;
	wire clock_out_enable_in;
	wire first_count_pin_in, second_count_pin_in, third_count_pin_in;
	wire trigger_pin_in;
	wire [3:0] pins;
	// Design outputs
	wire [15:0] timer0_count_out, timer1_count_out, timer2_count_out;
	wire [15:0] capture_out;
	wire [1:0] overflow_flag_out;
	wire third_overflow_flag_out, external_flag_out, irq_timer0_out;
	wire irq_timer1_out, irq_timer2_out, baud_tick_out, clock_out_pin_out;
	// Bench state
	int n_errors, samples_checked, n_baud, k, n, t;
	logic [31:0] rs;
	logic [15:0] v;
	logic [15:0] a[3];
	logic [15:0] d[3];

	assign {clock_out_enable_in, transmit_baud_select_in,
		receive_baud_select_in, down_count_enable_in, capture_clear_bit_in,
		trigger_enable_in, capture_reload_select_in, third_run_bit_in,
		third_source_select_in} = t2c;
	assign {trigger_pin_in, third_count_pin_in, second_count_pin_in,
		first_count_pin_in} = pins;

	ttc_top dut (.*);
	ttc_pin_partner pp (.sys_clk_in(sys_clk_in), .pins_out(pins));

	// 40 MHz clock
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	// Counts baud ticks seen
	always @(posedge sys_clk_in) begin
		if (baud_tick_out === 1'b1) n_baud++;
	end

	task end_sim();
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input string nm, input logic [15:0] got, input logic [15:0] e);
		samples_checked++;
		if (got !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, got);
		end
	endtask

	// Fixed-seed shift register source
	function automatic logic [31:0] rnd();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction

	function automatic logic [15:0] cnt(input int i);
		return (i == 0) ? timer0_count_out :
			(i == 1) ? timer1_count_out : timer2_count_out;
	endfunction

	// Reference step of a general timer
	function automatic logic [15:0] nxt(input logic [1:0] m, logic [15:0] c);
		logic [12:0] w;
		w = {c[15:8], c[4:0]} + 13'h0001;
		if (m == 2'h0) return {w[12:5], c[7:5], w[4:0]};
		if (m == 2'h2 && c[7:0] == 8'hff) return {c[15:8], c[15:8]};
		return c + 16'h0001;
	endfunction

	function automatic logic ovf(input logic [1:0] m, logic [15:0] c);
		if (m == 2'h0) return {c[15:8], c[4:0]} == 13'h1fff;
		if (m == 2'h2) return c[7:0] == 8'hff;
		return c == 16'hffff;
	endfunction

	task cyc(input int c);
		repeat (c) @(negedge sys_clk_in);
	endtask

	task wr(input logic [2:0] s, input logic [7:0] x);
		wr_en_in = 1'b1;
		wr_sel_in = s;
		wr_data_in = x;
		cyc(1);
		wr_en_in = 1'b0;
		cyc(1);
	endtask

	task w2(input logic [15:0] c, input logic [15:0] r);
		wr(3'h4, c[7:0]);
		wr(3'h5, c[15:8]);
		wr(3'h6, r[7:0]);
		wr(3'h7, r[15:8]);
	endtask

	// Clear pulses: {external, third, second, first}
	task clr(input logic [3:0] m);
		{clr_external_flag_in, clr_third_overflow_flag_in,
			clr_overflow_flag_in} = m;
		cyc(1);
		{clr_external_flag_in, clr_third_overflow_flag_in,
			clr_overflow_flag_in} = 4'h0;
		cyc(1);
	endtask

	// Bounded wait for a count to move
	task wchg(input int i, output logic [15:0] x);
		int c;
		for (c = 0; c < 200 && cnt(i) === v; c++) cyc(1);
		if (c == 200) begin
			chk("wait count", 16'h0000, 16'h0001);
			end_sim();
		end
		x = cnt(i);
	endtask

	task st2(input logic [15:0] e);
		v = cnt(2);
		wchg(2, v);
		chk("t2 count", v, e);
	endtask

	// Bounded wait for a clock-out level, returns cycles waited
	task wlev(input logic l, output int c);
		for (c = 0; c < 200 && clock_out_pin_out !== l; c++) cyc(1);
		if (c == 200) begin
			chk("wait level", 16'h0000, 16'h0001);
			end_sim();
		end
	endtask

	task snap();
		for (t = 0; t < 3; t++) a[t] = cnt(t);
	endtask

	task meas(input int c);
		snap();
		cyc(c);
		for (t = 0; t < 3; t++) d[t] = cnt(t) - a[t];
	endtask

	// Timer zero from a start value, compared at every step
	task gen(input logic [1:0] m, input logic [15:0] s, input int k2);
		logic [15:0] e;
		logic f;
		int j;
		run_bit_in = 2'b00;
		cyc(2);
		timer_mode_register_in = {6'h00, m};
		wr(3'h0, s[7:0]);
		wr(3'h1, s[15:8]);
		clr(4'hf);
		chk("t0 write", timer0_count_out, s);
		e = s;
		f = 1'b0;
		run_bit_in = 2'b01;
		for (j = 0; j < k2; j++) begin
			f = f | ovf(m, e);
			e = nxt(m, e);
			v = cnt(0);
			wchg(0, v);
			chk("t0 count", v, e);
			chk("t0 flag", overflow_flag_out[0], f);
			chk("t0 irq", irq_timer0_out, f);
		end
		run_bit_in = 2'b00;
		cyc(2);
	endtask

	initial begin
		rs = 32'h064f;
		{n_errors, samples_checked, n_baud} = '0;
		{ce_in, third_speed_select_in, rst_in} = 3'h7;
		{wr_en_in, timer_zero_speed_select_in} = 2'h0;
		timer_one_speed_select_in = 1'b0;
		{timer_mode_register_in, wr_data_in, wr_sel_in} = '0;
		{run_bit_in, clr_overflow_flag_in} = 4'h0;
		external_interrupt_pin_in = 2'b11;
		{clr_third_overflow_flag_in, clr_external_flag_in} = 2'h0;
		t2c = 9'h000;
		cyc(10);
		rst_in = 1'b0;
		cyc(2);
		// Time-base rates, slow first as left by reset
		timer_mode_register_in = 8'h11;
		run_bit_in = 2'b11;
		t2c = 9'h002;
		for (k = 0; k < 2; k++) begin
			{timer_zero_speed_select_in, timer_one_speed_select_in,
				third_speed_select_in} = {3{k[0]}};
			cyc(24);
			meas(240);
			chk("t0 rate", d[0], k ? 16'h003c : 16'h0014);
			chk("t1 rate", d[1], k ? 16'h003c : 16'h0014);
			chk("t2 rate", d[2], k ? 16'h003c : 16'h0014);
		end
		// Clock enable low freezes every count
		ce_in = 1'b0;
		meas(40);
		ce_in = 1'b1;
		chk("ce freeze", d[0] | d[1] | d[2], 16'h0000);
		// Gating: pin low, pin high, run bit off
		timer_mode_register_in = 8'h99;
		for (k = 0; k < 3; k++) begin
			run_bit_in = {2{k != 2}};
			external_interrupt_pin_in = {2{k != 0}};
			cyc(16);
			meas(48);
			chk("t0 gated", d[0], (k == 1) ? 16'h000c : 16'h0000);
			chk("t1 gated", d[1], (k == 1) ? 16'h000c : 16'h0000);
		end
		external_interrupt_pin_in = 2'b11;
		// Modes 0, 1 and 2 across carries and wraps
		gen(2'h0, 16'h121e, 2);
		gen(2'h0, 16'hff1e, 2);
		gen(2'h1, 16'hfffe, 2);
		gen(2'h2, {rnd() & 16'h007f, 8'hfe}, 3);
		// Counter function on all three count pins, random pace
		timer_mode_register_in = 8'h55;
		run_bit_in = 2'b11;
		t2c = 9'h007;
		n = int'(rnd() % 32'h8) + 1;
		cyc(16);
		snap();
		pp.pulse(4'h7, n, int'(rnd() % 32'h8) + 4);
		cyc(16);
		for (t = 0; t < 3; t++) begin
			d[t] = cnt(t) - a[t];
			chk("pin count", d[t], n[15:0]);
		end
		// Split mode, timer one frozen in its own mode 3
		run_bit_in = 2'b00;
		t2c = 9'h000;
		cyc(2);
		timer_mode_register_in = 8'h33;
		wr(3'h0, 8'h00);
		wr(3'h1, 8'h00);
		wr(3'h2, 8'h5a);
		wr(3'h3, 8'ha5);
		chk("t1 write", timer1_count_out, 16'ha55a);
		run_bit_in = 2'b11;
		cyc(16);
		meas(48);
		chk("split both", d[0], 16'h0c0c);
		chk("t1 frozen", d[1], 16'h0000);
		timer_mode_register_in = 8'h13;
		run_bit_in = 2'b01;
		cyc(16);
		meas(48);
		chk("split low", d[0], 16'h000c);
		chk("t1 no run", d[1], 16'h000c);
		run_bit_in = 2'b00;
		wr(3'h1, 8'hff);
		clr(4'hf);
		run_bit_in = 2'b10;
		cyc(16);
		chk("split tf1", overflow_flag_out[1], 1'b1);
		chk("irq1", irq_timer1_out, 1'b1);
		run_bit_in = 2'b00;
		// Third timer, capture mode wrap
		t2c = 9'h004;
		w2(16'hfffe, 16'h0000);
		t2c = 9'h006;
		st2(16'hffff);
		st2(16'h0000);
		cyc(2);
		chk("tf2 wrap", third_overflow_flag_out, 1'b1);
		chk("irq2", irq_timer2_out, 1'b1);
		// Trigger capture, then capture with clear
		for (k = 0; k < 2; k++) begin
			t2c = k ? 9'h01c : 9'h00c;
			clr(4'hc);
			w2(k ? 16'h0abc : 16'h1234, 16'h0000);
			pp.pulse(4'h8, 1, 8);
			cyc(8);
			chk("capture", capture_out, k ? 16'h0abc : 16'h1234);
			chk("external_flag", external_flag_out, 1'b1);
			chk("t2 kept", timer2_count_out, k ? 16'h0000 : 16'h1234);
		end
		// Up-only reload on wrap and on trigger
		clr(4'hc);
		t2c = 9'h000;
		w2(16'hfffe, 16'hfff0);
		t2c = 9'h002;
		st2(16'hffff);
		st2(16'hfff0);
		chk("tf2 reload", third_overflow_flag_out, 1'b1);
		t2c = 9'h008;
		clr(4'hc);
		w2(16'h0100, 16'h4321);
		pp.pulse(4'h8, 1, 8);
		cyc(8);
		chk("trig reload", timer2_count_out, 16'h4321);
		chk("trig external_flag", external_flag_out, 1'b1);
		// Up/down: up wrap, then down reload at the capture value
		clr(4'hc);
		t2c = 9'h020;
		w2(16'hfffe, 16'h0010);
		t2c = 9'h022;
		st2(16'hffff);
		st2(16'h0010);
		chk("ud tf2", third_overflow_flag_out, 1'b1);
		chk("ud external_flag", external_flag_out, 1'b1);
		t2c = 9'h020;
		clr(4'h4);
		cyc(2);
		chk("ud no irq", irq_timer2_out, 1'b0);
		pp.level(4'h8, 1'b0);
		cyc(16);
		t2c = 9'h022;
		st2(16'hffff);
		chk("ud toggle", external_flag_out, 1'b0);
		chk("ud tf2 dn", third_overflow_flag_out, 1'b1);
		t2c = 9'h020;
		pp.level(4'h8, 1'b1);
		// Baud mode: reload without flag, trigger still flags
		clr(4'hc);
		t2c = 9'h040;
		w2(16'hfffe, 16'hfffe);
		n_baud = 0;
		t2c = 9'h082;
		st2(16'hffff);
		st2(16'hfffe);
		t2c = 9'h048;
		cyc(2);
		chk("baud tf2", third_overflow_flag_out, 1'b0);
		chk("baud ticks", n_baud[15:0], 16'h0001);
		pp.pulse(4'h8, 1, 8);
		cyc(8);
		chk("baud external_flag", external_flag_out, 1'b1);
		chk("baud irq", irq_timer2_out, 1'b1);
		// Clock-out: period four times the capture value
		clr(4'hc);
		n = int'(rnd() % 32'h4) + 2;
		t2c = 9'h100;
		w2(16'h0000, n[15:0]);
		t2c = 9'h102;
		wlev(1'b1, k);
		wlev(1'b0, k);
		chk("clk high", k[15:0], 16'(2 * n));
		wlev(1'b1, k);
		chk("clk low", k[15:0], 16'(2 * n));
		chk("clk irq", irq_timer2_out, 1'b0);
		end_sim();
	end
endmodule // tb_top

// [verification/ttc_pin_partner.sv]
// Outside source on the count pins and the trigger pin
`timescale 1ns/100ps
module ttc_pin_partner (
	// Clock
	input wire logic sys_clk_in,
	// Pins: [0] first, [1] second, [2] third count, [3] trigger
	output logic [3:0] pins_out
);
	// Idle high, like a pulled-up port pin
	initial begin
		pins_out = 4'hf;
	end

	// Falls on masked pins; a level shorter than a machine cycle may be lost
	task pulse(input logic [3:0] m, input int n, input int h);
		int i;
		for (i = 0; i < n; i++) begin
			repeat (h) @(negedge sys_clk_in);
			pins_out = pins_out & ~m;
			repeat (h) @(negedge sys_clk_in);
			pins_out = pins_out | m;
		end
	endtask

	// Static level, used as the up/down direction
	task level(input logic [3:0] m, input logic v);
		@(negedge sys_clk_in);
		pins_out = v ? (pins_out | m) : (pins_out & ~m);
	endtask
endmodule // ttc_pin_partner
